/* common/cmd_limiter_pkg.sv */
// Shared constants and types for the speed and torque command limiter
package cmd_limiter_pkg;
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_CONFIG    = 8'h04;
    localparam logic [7:0] ADDR_SPD_UPPER = 8'h08;
    localparam logic [7:0] ADDR_SPD_LOWER = 8'h0c;
    localparam logic [7:0] ADDR_TRQ_MAX   = 8'h10;
    localparam logic [7:0] ADDR_EXT_SRC   = 8'h14;
    localparam logic [7:0] ADDR_SPD_GAIN  = 8'h18;
    localparam logic [7:0] ADDR_SPD_OFF   = 8'h1c;
    localparam logic [7:0] ADDR_TRQ_GAIN  = 8'h20;
    localparam logic [7:0] ADDR_TRQ_OFF   = 8'h24;
    localparam logic [7:0] ADDR_OP_SPEED  = 8'h28;
    localparam logic [7:0] ADDR_OP_TORQUE = 8'h2c;
    localparam logic [7:0] ADDR_SPD_CMD   = 8'h30;
    localparam logic [7:0] ADDR_TRQ_CMD   = 8'h34;
    localparam logic [7:0] ADDR_INFO      = 8'h38;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h3c;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h40;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h44;
    // Control and interrupt register fields
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_TRQ_BIT  = 1;
    localparam int CTRL_EXT_BIT  = 2;
    localparam int IRQ_SPD_BIT   = 0;
    localparam int IRQ_TRQ_BIT   = 1;
    // Ranges and factory values, speed in r/min, torque in percent
    localparam logic [11:0] SPD_MIN       = 12'd80;
    localparam logic [11:0] SPD_MAX       = 12'd3150;
    localparam logic [11:0] SPD_UPPER_RST = 12'd3150;
    localparam logic [11:0] SPD_LOWER_RST = 12'd80;
    localparam logic [11:0] SPD_GAIN_MAX  = 12'd3150;
    localparam logic [11:0] SPD_GAIN_RST  = 12'd640;
    localparam logic [11:0] SPD_OFF_LIM   = 12'd1500;
    localparam logic [7:0]  TRQ_PEAK      = 8'd200;
    localparam logic [7:0]  TRQ_MAX_RST   = 8'd200;
    localparam logic [7:0]  TRQ_GAIN_MAX  = 8'd200;
    localparam logic [7:0]  TRQ_GAIN_RST  = 8'd43;
    localparam logic [7:0]  TRQ_OFF_LIM   = 8'd100;
    localparam logic        EXT_SRC_RST   = 1'b0;
    // Analog input in mV, PWM duty in per mille
    localparam logic [25:0] MV_PER_V      = 26'd1000;
    localparam logic [21:0] DUTY_FULL     = 22'd1000;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0]  HTRANS_SEQ    = 2'b11;

    typedef struct packed {
        logic [11:0] speed;
        logic [7:0]  torque;
        logic        speed_err;
        logic        torque_err;
    } limiter_out_type;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  addr;
    } bus_req_type;
endpackage : cmd_limiter_pkg

/* verif/setting_source_model.sv */
// External setting device: analog voltage or PWM duty source
`timescale 1ns/10ps
`default_nettype none
module setting_source_model (
    input  wire logic        hclk,
    input  wire logic        use_pwm,
    input  wire logic [13:0] level_mv,
    input  wire logic [9:0]  duty_pm,
    output logic      [13:0] analog_mv,
    output logic      [9:0]  pwm_duty_pm
);
    logic [9:0] noise_r;
    initial begin
        noise_r = 10'h155;
        analog_mv = 14'h0000;
        pwm_duty_pm = 10'h000;
    end
    // Unselected source wanders, so a wrong selection cannot pass by luck
    always @(posedge hclk) begin
        noise_r     <= noise_r + 10'h0cb;
        analog_mv   <= use_pwm ? {4'h0, noise_r} : level_mv;
        pwm_duty_pm <= use_pwm ? duty_pm : noise_r;
    end
endmodule : setting_source_model
`default_nettype wire

/* verif/speed_torque_command_limiter_tb.sv */
// Self-checking bench for the speed and torque command limiter
`timescale 1ns/10ps
`default_nettype none
module speed_torque_command_limiter_tb;
    import cmd_limiter_pkg::*;
    logic            hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, use_pwm;
    logic [31:0]     haddr, hwdata, hrdata;
    logic [1:0]      htrans;
    logic [2:0]      hsize;
    logic [13:0]     analog_mv, level_mv;
    logic [9:0]      pwm_duty_pm, duty_pm;
    limiter_out_type cmd_out;
    int              err_count, n_tests;

    speed_torque_command_limiter i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .analog_mv(analog_mv),
        .pwm_duty_pm(pwm_duty_pm), .cmd_out(cmd_out), .irq(irq));
    setting_source_model i_src (.hclk(hclk), .use_pwm(use_pwm), .level_mv(level_mv),
        .duty_pm(duty_pm), .analog_mv(analog_mv), .pwm_duty_pm(pwm_duty_pm));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                            output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0, "okay response");
    endtask : bus_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus_xfer(1'b1, a, d, unused);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        bus_xfer(1'b0, a, 32'h0, v);
        chk(v, exp, what);
    endtask : rd_chk

    // Command path answers two edges after a change; four leaves margin
    task automatic out_chk(input logic [11:0] s, input logic se, input logic [7:0] t, input logic te,
                           input string what);
        repeat (4) @(posedge hclk);
        chk({10'h000, cmd_out}, {10'h000, s, t, se, te}, what);
    endtask : out_chk

    task automatic test_reset;
        logic [7:0]  a[11] = '{ADDR_SPD_UPPER, ADDR_SPD_LOWER, ADDR_TRQ_MAX, ADDR_EXT_SRC, ADDR_SPD_GAIN,
                              ADDR_SPD_OFF, ADDR_TRQ_GAIN, ADDR_TRQ_OFF, ADDR_CTRL, ADDR_IRQ_STAT, 8'h80};
        logic [31:0] e[11] = '{32'hc4e, 32'h50, 32'hc8, 32'h0, 32'h280, 32'h0, 32'h2b, 32'h0, 32'h2, 32'h0, 32'h0};
        for (int i = 0; i < 11; i++) begin
            rd_chk(a[i], e[i], "reset value");
        end
        $display("Test reset values done");
    endtask : test_reset

    task automatic test_speed_clamp;
        logic [11:0] op[8] = '{12'hbb8, 12'h064, 12'h3e8, 12'h000, 12'h04f, 12'h050, 12'h9c4, 12'h1f4};
        logic [11:0] ex[8] = '{12'h9c4, 12'h1f4, 12'h3e8, 12'h000, 12'h000, 12'h1f4, 12'h9c4, 12'h1f4};
        logic        er[8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        wr(ADDR_SPD_UPPER, 32'h9c4);
        wr(ADDR_SPD_LOWER, 32'h1f4);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_OP_SPEED, {20'h00000, op[i]});
            out_chk(ex[i], er[i], 8'h00, 1'b0, "digital speed");
        end
        $display("Test speed clamps done");
    endtask : test_speed_clamp

    task automatic test_torque;
        wr(ADDR_TRQ_MAX, 32'ha0);
        wr(ADDR_OP_SPEED, 32'h3e8);
        wr(ADDR_OP_TORQUE, 32'hb4);
        out_chk(12'h3e8, 1'b0, 8'ha0, 1'b1, "torque over max");
        rd_chk(ADDR_INFO, 32'h2, "info flags");
        wr(ADDR_OP_TORQUE, 32'h96);
        out_chk(12'h3e8, 1'b0, 8'h96, 1'b0, "torque under max");
        wr(ADDR_OP_TORQUE, 32'hb4);
        wr(ADDR_CTRL, 32'h0);
        out_chk(12'h3e8, 1'b0, 8'hb4, 1'b0, "torque function off");
        wr(ADDR_OP_TORQUE, 32'hfa);
        out_chk(12'h3e8, 1'b0, 8'hc8, 1'b0, "peak cap function off");
        $display("Test torque limit done");
    endtask : test_torque

    task automatic test_analog;
        level_mv <= 14'h07d0;
        wr(ADDR_CTRL, 32'h6);
        out_chk(12'h500, 1'b0, 8'h56, 1'b0, "analog gains");
        wr(ADDR_SPD_OFF, 32'h64);
        wr(ADDR_TRQ_OFF, 32'h14);
        out_chk(12'h564, 1'b0, 8'h6a, 1'b0, "analog offsets");
        wr(ADDR_TRQ_GAIN, 32'hc8);
        out_chk(12'h564, 1'b0, 8'ha0, 1'b1, "analog torque clamp");
        wr(ADDR_SPD_OFF, 32'hfffffa24);
        out_chk(12'h000, 1'b0, 8'ha0, 1'b1, "negative offset stop");
        wr(ADDR_SPD_OFF, 32'hfffffb50);
        out_chk(12'h1f4, 1'b1, 8'ha0, 1'b1, "offset reaches 80");
        wr(ADDR_SPD_OFF, 32'h64);
        wr(ADDR_TRQ_GAIN, 32'h2b);
        $display("Test analog scaling done");
    endtask : test_analog

    task automatic test_source;
        duty_pm <= 10'h1f4;
        wr(ADDR_EXT_SRC, 32'h1);
        out_chk(12'h564, 1'b0, 8'h6a, 1'b0, "source before config");
        wr(ADDR_CONFIG, 32'h0);
        use_pwm <= 1'b1;
        out_chk(12'h627, 1'b0, 8'h64, 1'b0, "pwm source");
        rd_chk(ADDR_EXT_SRC, 32'h1, "source readback");
        wr(ADDR_CTRL, 32'h7);
        wr(ADDR_SPD_UPPER, 32'h3e8);
        out_chk(12'h627, 1'b0, 8'h64, 1'b0, "upper held while running");
        rd_chk(ADDR_SPD_UPPER, 32'h3e8, "upper readback");
        wr(ADDR_CTRL, 32'h6);
        out_chk(12'h3e8, 1'b1, 8'h64, 1'b0, "upper after stop");
        $display("Test source and update classes done");
    endtask : test_source

    task automatic test_irq;
        wr(ADDR_CTRL, 32'h2);
        use_pwm <= 1'b0;
        wr(ADDR_OP_SPEED, 32'h2bc);
        wr(ADDR_OP_TORQUE, 32'h96);
        out_chk(12'h2bc, 1'b0, 8'h96, 1'b0, "in range");
        wr(ADDR_IRQ_EN, 32'h0);
        wr(ADDR_IRQ_CLR, 32'h3);
        rd_chk(ADDR_IRQ_STAT, 32'h0, "status cleared");
        wr(ADDR_OP_SPEED, 32'hbb8);
        out_chk(12'h3e8, 1'b1, 8'h96, 1'b0, "speed clamp event");
        rd_chk(ADDR_IRQ_STAT, 32'h1, "status sticky");
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(ADDR_IRQ_EN, 32'h3);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h1, "irq enabled");
        wr(ADDR_IRQ_CLR, 32'h1);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rd_chk(ADDR_IRQ_STAT, 32'h0, "no new event");
        rd_chk(ADDR_IRQ_CLR, 32'h0, "clear write only");
        rd_chk(ADDR_IRQ_EN, 32'h3, "enable readback");
        wr(8'h80, 32'h1234);
        rd_chk(8'h80, 32'h0, "unmapped");
        $display("Test interrupts done");
    endtask : test_irq

    task automatic results;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial begin
        {hresetn, hsel, hwrite, use_pwm} = 4'h0;
        {haddr, hwdata} = 64'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        level_mv = 14'h0000;
        duty_pm = 10'h000;
        err_count = 0;
        n_tests = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset();
        test_speed_clamp();
        test_torque();
        test_analog();
        test_source();
        test_irq();
        results();
    end

    // Whole sequence needs a few hundred cycles
    initial begin
        #(40 * 20000);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end
endmodule : speed_torque_command_limiter_tb
`default_nettype wire

/* verilog/speed_torque_command_limiter.sv */
// Speed and torque command limiter with AHB-Lite parameter registers
//
// Operation
// - Speed upper and lower limits settable 80..3150, reset 3150 and 80.
// - Speed above the upper limit runs at the upper limit.
// - Speed below the lower limit is raised to the lower limit.
// - Commands of 0..79 r/min are exempt from the lower limit.
// - Zero speed command never gets the lower limit; output stays zero.
// - Speed error flag is high while either speed limit clamps.
// - Torque maximum settable 0..200, reset 200; larger torque is reduced.
// - Torque error flag is high while the torque maximum reduces.
// - Torque function off: cap at 200 peak, ignore maximum, no flag.
// - Source selector: 0 analog, 1 PWM; reset 0.
// - Analog speed gain per volt 0..3150, reset 640.
// - Signed speed offset -1500..+1500, reset 0, added to analog speed.
// - Analog torque gain per volt 0..200, reset 43.
// - Signed torque offset -100..+100, reset 0, added to analog torque.
// - With negative offset the motor stays stopped below 80 r/min.
`timescale 1ns/10ps
`default_nettype none
module speed_torque_command_limiter (
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    input  wire logic                            hsel,
    input  wire logic [31:0]                     haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic                                 hreadyout,
    output logic                                 hresp,
    output logic [31:0]                          hrdata,
    input  wire logic [13:0]                     analog_mv,
    input  wire logic [9:0]                      pwm_duty_pm,
    output cmd_limiter_pkg::limiter_out_type     cmd_out,
    output logic                                 irq
);
    import cmd_limiter_pkg::*;

    function automatic logic [11:0] clip_u(input logic [31:0] v, input logic [11:0] lo, input logic [11:0] hi);
        if (v < {20'd0, lo})
            clip_u = lo;
        else if (v > {20'd0, hi})
            clip_u = hi;
        else
            clip_u = v[11:0];
    endfunction : clip_u

    function automatic logic [11:0] clip_s(input logic [31:0] v, input logic [11:0] lim);
        if ($signed(v) > $signed({20'd0, lim}))
            clip_s = lim;
        else if ($signed(v) < -$signed({20'd0, lim}))
            clip_s = 12'd0 - lim;
        else
            clip_s = v[11:0];
    endfunction : clip_s

    // Bus request and data phase
    bus_req_type       req;
    bus_req_type       dph_r;
    logic              ctrl_run_r;
    logic              ctrl_trq_r;
    logic              ctrl_ext_r;
    logic [11:0]       spd_upper_w_r;
    logic [11:0]       spd_lower_w_r;
    logic [7:0]        trq_max_w_r;
    logic              ext_src_w_r;
    logic [11:0]       spd_upper_r;
    logic [11:0]       spd_lower_r;
    logic [7:0]        trq_max_r;
    logic              ext_src_r;
    logic [11:0]       spd_gain_r;
    logic signed [11:0] spd_off_r;
    logic [7:0]        trq_gain_r;
    logic signed [7:0] trq_off_r;
    logic [11:0]       op_speed_r;
    logic [7:0]        op_torque_r;
    logic [1:0]        irq_stat_r;
    logic [1:0]        irq_en_r;
    logic [31:0]       hrdata_r;
    logic signed [17:0] spd_raw_r;
    logic signed [17:0] trq_raw_r;
    limiter_out_type   out_r;

    wire               xfer     = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign req.write = xfer && hwrite;
    assign req.read  = xfer && !hwrite;
    assign req.addr  = haddr[7:0];

    wire               wr_en    = dph_r.write;
    wire [7:0]         wa       = dph_r.addr;
    wire               cfg_pulse = wr_en && wa == ADDR_CONFIG;
    wire [1:0]         irq_clr  = (wr_en && wa == ADDR_IRQ_CLR) ? hwdata[1:0] : 2'b00;

    // Saturated write values; the narrow registers keep the low bits
    wire [11:0]        trq_max_sat  = clip_u(hwdata, 12'd0, {4'd0, TRQ_PEAK});
    wire [11:0]        trq_gain_sat = clip_u(hwdata, 12'd0, {4'd0, TRQ_GAIN_MAX});
    wire [11:0]        trq_off_sat  = clip_s(hwdata, {4'd0, TRQ_OFF_LIM});

    // Data path: scale and offset
    wire [25:0]        spd_prod = spd_gain_r * analog_mv;
    wire [25:0]        spd_scl  = spd_prod / MV_PER_V;
    wire signed [17:0] spd_an   = $signed({1'b0, spd_scl[16:0]}) + spd_off_r;
    wire [21:0]        trq_prod = trq_gain_r * analog_mv;
    wire [21:0]        trq_scl  = trq_prod / MV_PER_V[21:0];
    wire signed [17:0] trq_an   = $signed({1'b0, trq_scl[16:0]}) + trq_off_r;
    // PWM duty maps across the full speed and peak torque span
    wire [21:0]        spd_pp   = pwm_duty_pm * SPD_MAX;
    wire [21:0]        trq_pp   = pwm_duty_pm * TRQ_PEAK;
    wire [21:0]        spd_pw   = spd_pp / DUTY_FULL;
    wire [21:0]        trq_pw   = trq_pp / DUTY_FULL;
    wire signed [17:0] spd_ext  = ext_src_r ? $signed({6'd0, spd_pw[11:0]}) : spd_an;
    wire signed [17:0] trq_ext  = ext_src_r ? $signed({10'd0, trq_pw[7:0]}) : trq_an;
    wire signed [17:0] spd_sel  = ctrl_ext_r ? spd_ext : $signed({6'd0, op_speed_r});
    wire signed [17:0] trq_sel  = ctrl_ext_r ? trq_ext : $signed({10'd0, op_torque_r});

    // Clamp stage works on the registered sums
    wire signed [17:0] s_upper  = $signed({6'd0, spd_upper_r});
    wire signed [17:0] s_lower  = $signed({6'd0, spd_lower_r});
    wire signed [17:0] s_min    = $signed({6'd0, SPD_MIN});
    wire               spd_stop = spd_raw_r < s_min;
    wire               spd_hi   = !spd_stop && spd_raw_r > s_upper;
    wire               spd_lo   = !spd_stop && !spd_hi && spd_raw_r < s_lower;
    wire [11:0]        spd_lim  = spd_stop ? 12'd0 :
                                  spd_hi   ? spd_upper_r :
                                  spd_lo   ? spd_lower_r : spd_raw_r[11:0];
    wire               spd_err  = spd_hi || spd_lo;
    wire signed [17:0] s_tmax   = $signed({10'd0, trq_max_r});
    wire signed [17:0] s_tpeak  = $signed({10'd0, TRQ_PEAK});
    wire               trq_neg  = trq_raw_r < 18'sd0;
    wire               trq_pk   = !trq_neg && trq_raw_r > s_tpeak;
    wire               trq_mx   = ctrl_trq_r && !trq_neg && trq_raw_r > s_tmax;
    wire [7:0]         trq_lim  = trq_neg ? 8'd0 :
                                  trq_mx  ? trq_max_r :
                                  trq_pk  ? TRQ_PEAK : trq_raw_r[7:0];
    // Events are flag rises, so a held clamp raises only one event
    wire [1:0]         irq_set  = {trq_mx && !out_r.torque_err, spd_err && !out_r.speed_err};

    // Read mux, sampled in the address phase so hrdata is a flop
    wire [31:0]        rd_mux   =
        req.addr == ADDR_CTRL      ? {29'd0, ctrl_ext_r, ctrl_trq_r, ctrl_run_r} :
        req.addr == ADDR_SPD_UPPER ? {20'd0, spd_upper_w_r} :
        req.addr == ADDR_SPD_LOWER ? {20'd0, spd_lower_w_r} :
        req.addr == ADDR_TRQ_MAX   ? {24'd0, trq_max_w_r} :
        req.addr == ADDR_EXT_SRC   ? {31'd0, ext_src_w_r} :
        req.addr == ADDR_SPD_GAIN  ? {20'd0, spd_gain_r} :
        req.addr == ADDR_SPD_OFF   ? {{20{spd_off_r[11]}}, spd_off_r} :
        req.addr == ADDR_TRQ_GAIN  ? {24'd0, trq_gain_r} :
        req.addr == ADDR_TRQ_OFF   ? {{24{trq_off_r[7]}}, trq_off_r} :
        req.addr == ADDR_OP_SPEED  ? {20'd0, op_speed_r} :
        req.addr == ADDR_OP_TORQUE ? {24'd0, op_torque_r} :
        req.addr == ADDR_SPD_CMD   ? {20'd0, out_r.speed} :
        req.addr == ADDR_TRQ_CMD   ? {24'd0, out_r.torque} :
        req.addr == ADDR_INFO      ? {30'd0, out_r.torque_err, out_r.speed_err} :
        req.addr == ADDR_IRQ_STAT  ? {30'd0, irq_stat_r} :
        req.addr == ADDR_IRQ_EN    ? {30'd0, irq_en_r} : 32'd0;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign cmd_out   = out_r;
    assign irq       = |(irq_stat_r & irq_en_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_r    <= '0;
            hrdata_r <= 32'd0;
        end else begin
            dph_r    <= req;
            hrdata_r <= req.read ? rd_mux : 32'd0;
        end
    end

    // Software-written registers, held in range on write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_run_r    <= 1'b0;
            ctrl_trq_r    <= 1'b1;
            ctrl_ext_r    <= 1'b0;
            spd_upper_w_r <= SPD_UPPER_RST;
            spd_lower_w_r <= SPD_LOWER_RST;
            trq_max_w_r   <= TRQ_MAX_RST;
            ext_src_w_r   <= EXT_SRC_RST;
            spd_gain_r    <= SPD_GAIN_RST;
            spd_off_r     <= 12'sd0;
            trq_gain_r    <= TRQ_GAIN_RST;
            trq_off_r     <= 8'sd0;
            op_speed_r    <= 12'd0;
            op_torque_r   <= 8'd0;
            irq_en_r      <= 2'b00;
        end else if (wr_en) begin
            unique case (wa)
                ADDR_CTRL: begin
                    ctrl_run_r <= hwdata[CTRL_RUN_BIT];
                    ctrl_trq_r <= hwdata[CTRL_TRQ_BIT];
                    ctrl_ext_r <= hwdata[CTRL_EXT_BIT];
                end
                ADDR_SPD_UPPER: spd_upper_w_r <= clip_u(hwdata, SPD_MIN, SPD_MAX);
                ADDR_SPD_LOWER: spd_lower_w_r <= clip_u(hwdata, SPD_MIN, SPD_MAX);
                ADDR_TRQ_MAX:   trq_max_w_r <= trq_max_sat[7:0];
                ADDR_EXT_SRC:   ext_src_w_r <= hwdata[0];
                ADDR_SPD_GAIN:  spd_gain_r <= clip_u(hwdata, 12'd0, SPD_GAIN_MAX);
                ADDR_SPD_OFF:   spd_off_r <= clip_s(hwdata, SPD_OFF_LIM);
                ADDR_TRQ_GAIN:  trq_gain_r <= trq_gain_sat[7:0];
                ADDR_TRQ_OFF:   trq_off_r <= trq_off_sat[7:0];
                ADDR_OP_SPEED:  op_speed_r <= (hwdata[31:12] != 20'd0) ? 12'hfff : hwdata[11:0];
                ADDR_OP_TORQUE: op_torque_r <= (hwdata[31:8] != 24'd0) ? 8'hff : hwdata[7:0];
                ADDR_IRQ_EN:    irq_en_r <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // Class B copies follow only while stopped, class C on configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spd_upper_r <= SPD_UPPER_RST;
            spd_lower_r <= SPD_LOWER_RST;
            trq_max_r   <= TRQ_MAX_RST;
            ext_src_r   <= EXT_SRC_RST;
        end else begin
            if (!ctrl_run_r) begin
                spd_upper_r <= spd_upper_w_r;
                spd_lower_r <= spd_lower_w_r;
                trq_max_r   <= trq_max_w_r;
            end
            if (cfg_pulse)
                ext_src_r <= ext_src_w_r;
        end
    end

    // Two stages: sum first, clamp afterwards
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spd_raw_r <= 18'sd0;
            trq_raw_r <= 18'sd0;
            out_r     <= '0;
        end else begin
            spd_raw_r        <= spd_sel;
            trq_raw_r        <= trq_sel;
            out_r.speed      <= spd_lim;
            out_r.speed_err  <= spd_err;
            out_r.torque     <= trq_lim;
            out_r.torque_err <= trq_mx;
        end
    end

    // A new clamp event beats a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq_stat_r <= 2'b00;
        else
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Speed clamps; outputs lag the registered sums by one edge
    a_upper_clamp: assert property (
        (!spd_stop && spd_raw_r > s_upper)
        |=> out_r.speed == $past(spd_upper_r))
        else $error("speed not held at upper limit");

    a_lower_raise: assert property (
        spd_lo
        |=> out_r.speed == $past(spd_lower_r) && out_r.speed_err)
        else $error("speed not raised to lower limit");

    a_low_exempt: assert property (
        spd_raw_r < s_min
        |=> out_r.speed == 12'd0 && !out_r.speed_err)
        else $error("low speed command not exempt");

    a_zero_hold: assert property (
        spd_raw_r == 18'sd0 [*2]
        |=> out_r.speed == 12'd0 && !out_r.speed_err)
        else $error("zero speed not held at zero");

    a_spd_flag: assert property (
        out_r.speed_err
        |-> $past(spd_raw_r) != $signed({6'd0, out_r.speed}))
        else $error("speed flag without clamping");

    a_spd_window: assert property (
        out_r.speed != 12'd0
        |-> out_r.speed >= SPD_MIN && out_r.speed <= SPD_MAX)
        else $error("speed command outside settable range");

    a_spd_pass: assert property (
        !spd_stop && spd_raw_r >= s_lower && spd_raw_r <= s_upper
        |=> out_r.speed == $past(spd_raw_r[11:0]) && !out_r.speed_err)
        else $error("in-range speed not passed through");

    // Torque clamps
    a_trq_max: assert property (
        ctrl_trq_r && trq_raw_r > s_tmax
        |=> out_r.torque == $past(trq_max_r))
        else $error("torque not reduced to maximum");

    a_trq_flag: assert property (
        out_r.torque_err
        |-> $past(trq_raw_r) > $signed({10'd0, out_r.torque}))
        else $error("torque flag without reduction");

    a_trq_off: assert property (
        !ctrl_trq_r [*2]
        |-> !out_r.torque_err && out_r.torque <= TRQ_PEAK)
        else $error("torque function off misbehaves");

    a_trq_cap: assert property (
        out_r.torque <= TRQ_PEAK)
        else $error("torque command above peak");

    a_trq_peak_off: assert property (
        !ctrl_trq_r && trq_raw_r > s_tpeak
        |=> out_r.torque == TRQ_PEAK && !out_r.torque_err)
        else $error("torque not capped at peak");

    a_trq_pass: assert property (
        ctrl_trq_r && !trq_neg && trq_raw_r <= s_tmax
        |=> out_r.torque == $past(trq_raw_r[7:0]) && !out_r.torque_err)
        else $error("in-range torque not passed through");

    a_trq_neg_zero: assert property (
        trq_neg
        |=> out_r.torque == 8'd0 && !out_r.torque_err)
        else $error("negative torque sum not floored");

    // Update classes and events
    a_src_config: assert property (
        $changed(ext_src_r)
        |-> $past(cfg_pulse))
        else $error("source changed without configuration");

    a_class_b: assert property (
        ctrl_run_r && $past(ctrl_run_r)
        |-> $stable(spd_upper_r) && $stable(trq_max_r))
        else $error("class B value changed while running");

    a_cfg_apply: assert property (
        cfg_pulse
        |=> ext_src_r == $past(ext_src_w_r))
        else $error("configuration did not apply source");

    a_class_b_follow: assert property (
        !ctrl_run_r
        |=> spd_lower_r == $past(spd_lower_w_r) && trq_max_r == $past(trq_max_w_r))
        else $error("class B value not applied while stopped");

    a_irq_sticky: assert property (
        irq_set[IRQ_SPD_BIT] |=> irq_stat_r[IRQ_SPD_BIT]
        ##1 (irq_stat_r[IRQ_SPD_BIT] || $past(irq_clr[IRQ_SPD_BIT])))
        else $error("speed event lost");

    a_trq_sticky: assert property (
        irq_set[IRQ_TRQ_BIT]
        |=> irq_stat_r[IRQ_TRQ_BIT])
        else $error("torque event lost");

    // Main scenarios
    c_upper: cover property (spd_hi ##1 out_r.speed_err);

    c_lower: cover property (spd_lo ##1 out_r.speed_err);

    c_trq: cover property (trq_mx ##1 irq);

    c_config: cover property (cfg_pulse ##1 $changed(ext_src_r));

    c_low_exempt: cover property (spd_stop && spd_raw_r > 18'sd0 ##1 out_r.speed == 12'd0);
endmodule : speed_torque_command_limiter
`default_nettype wire
